/* File: rtl/ect_defs.svh */
// Constants for the event capture timer: codes, divider taps and timing.
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH

// Operating mode codes.
`define ECT_MODE_TEV 2'b00
`define ECT_MODE_WIN 2'b01
`define ECT_MODE_PW  2'b10
`define ECT_MODE_PPG 2'b11

// Start control codes.
`define ECT_START_STOP 2'b00
`define ECT_START_CMD  2'b01
`define ECT_START_RISE 2'b10
`define ECT_START_FALL 2'b11

// Source clock select codes.
`define ECT_CLK_SLOW 2'b00
`define ECT_CLK_MID  2'b01
`define ECT_CLK_FAST 2'b10
`define ECT_CLK_EXT  2'b11

// Divider taps: the source clock is the high-frequency clock over 2^n.
`define ECT_DIV_SLOW 11
`define ECT_DIV_MID  7
`define ECT_DIV_FAST 3
// Low-frequency source is the low-frequency clock over 2^3.
`define ECT_FS_DIV   3

// Pin filter, in high-frequency clock periods (mclk is that clock).
`define ECT_REJECT_FC 4
`define ECT_DETECT_FC 12
`define ECT_FILT_CYC  ((`ECT_REJECT_FC + `ECT_DETECT_FC) / 2)

// Counter reset value and the value a single-edge capture rests at.
`define ECT_CNT_RESET 16'h0000
`define ECT_CNT_REST  16'h0001

`endif

/* File: rtl/ect_pkg.sv */
// Types shared by the event capture timer modules.
package ect_pkg;

  // Control fields of the timer control register.
  typedef struct packed {
    logic [1:0] operating_mode_sel;
    logic [1:0] start_control;
    logic [1:0] source_clock_sel;
    logic       auto_capture_en;
    logic       capture_edge_mode;
    logic       trigger_stop_sel;
    logic       divider_tap_sel;
  } ect_ctrl_t;

  // Counter sequencing state.
  typedef enum logic [1:0] {
    ECT_ST_STOP,
    ECT_ST_WAIT,
    ECT_ST_RUN
  } ect_state_t;

endpackage

/* File: rtl/ect_pin_filter.sv */
// Input pin synchroniser and noise filter for the count input.
`timescale 1ns/1ps
`default_nettype none

`include "ect_defs.svh"

module ect_pin_filter #(
  parameter int FILT_CYC = `ECT_FILT_CYC
) (
  input  wire logic mclk,      // System clock.
  input  wire logic rst,       // Synchronous reset, active high.
  input  wire logic pin,       // Raw asynchronous pin.
  input  wire logic bypass,    // Low-speed modes skip the filter.
  output logic      level      // Filtered level.
);

  logic       sync1_q;
  logic       sync2_q;
  logic       level_q;
  logic [4:0] run_q;

  ////////////////////////////////////////////////////////////////////////
  // Two flops bring the pin into the clock domain.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A new level is accepted only after it stands for FILT_CYC samples.
  // With bypass low, short glitches restart the count, so they never reach the timer.
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_q <= 1'b0;
      run_q   <= 5'h00;
    end else if (bypass) begin
      level_q <= sync2_q;
      run_q   <= 5'h00;
    end else if (sync2_q == level_q) begin
      run_q <= 5'h00; // R10
    end else if (run_q == 5'(FILT_CYC - 1)) begin
      level_q <= sync2_q; // R10
      run_q   <= 5'h00;
    end else begin
      run_q <= run_q + 5'h01;
    end
  end

  assign level = level_q;

  // A filtered change must follow a full run of differing samples.
  filt_change_a: assert property (@(posedge mclk) disable iff (rst) // R10
    (!bypass && $changed(level_q)) |-> ($past(run_q) == 5'(FILT_CYC - 1)))
    else $error("Filter passed a pulse that was too short.");

endmodule

`default_nettype wire

/* File: rtl/ect_timer.sv */
// Event capture timer: 16-bit up counter with five operating modes.
`timescale 1ns/1ps
`default_nettype none

`include "ect_defs.svh"

// Behaviour
// [R01] Timer mode: count ticks, match interrupts and wraps.
// [R02] Auto-capture copies counter on every count tick; trigger-start mode never auto-captures.
// [R03] Software reads auto-capture only while running.
// [R04] Software waits one tick before first read.
// [R05] Clock select picks divider tap; low-speed slow only.
// [R06] External trigger: counting starts after trigger edge.
// [R07] External trigger match clears, halts, interrupts.
// [R08] Stop-select: opposite edge clears, halts, no interrupt.
// [R09] Without stop-select, extra edges do nothing.
// [R10] Pin filter rejects short pulses, bypassed when slow.
// [R11] Event mode counts edges; match at opposite edge.
// [R12] Source holds each pin level two cycles.
// [R13] Window mode counts ticks gated by pin level.
// [R14] Window input changes much slower than ticks.
// [R15] Single-edge capture: capture, interrupt, rest at one.
// [R16] Software picks trigger edge by measured level.
// [R17] Double-edge capture: capture at both edges.
// [R18] Software reads capture before next trigger edge.
// [R19] Software discards first pulse-width capture.
// [R20] Mode field selects mode; generator mode idles.
// [R21] Start code stop clears; command start runs.
// [R22] Sixteen-bit registers; interrupt is one-cycle pulse.
module ect_timer
  import ect_pkg::*;
#(
  parameter int CW       = 16,
  parameter int FILT_CYC = `ECT_FILT_CYC
) (
  input  wire logic      mclk,              // System clock, high freq.
  input  wire logic      rst,               // Synchronous reset.
  input  wire ect_ctrl_t timer_control_reg, // Control fields.
  input  wire logic [CW-1:0] compare_limit_reg, // Match limit.
  input  wire logic      low_speed_mode,    // Low-speed or sleep mode.
  input  wire logic      ext_count_input,   // Raw count/trigger pin.
  input  wire logic      low_freq_clock,    // Raw low-frequency clock.
  output logic [CW-1:0]  capture_reg,       // Captured count.
  output logic [CW-1:0]  count_value,       // Running count.
  output logic           counting,          // Counter is advancing.
  output logic           timer_match_irq    // One-cycle request.
);

  ect_ctrl_t  ctl;
  ect_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cap_q;
  logic          irq_q;
  logic [`ECT_DIV_SLOW-1:0] div_q;
  logic [`ECT_FS_DIV-1:0]   fsdiv_q;
  logic fs_s1_q, fs_s2_q, fs_s3_q;
  logic pin_lvl, pin_prev_q;
  logic rise, fall, trig_edge, opp_edge;
  logic tick, fs_tick, slow_src;
  logic m_timer, m_ext, m_event, m_win, m_pw;
  logic win_lvl, hit, run, cnt_adv, cap_pw;

  assign ctl = timer_control_reg;

  ////////////////////////////////////////////////////////////////////////
  // Count pin passes through the synchroniser and glitch filter.
  ect_pin_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filter (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (ext_count_input),
    .bypass (low_speed_mode), // R10
    .level  (pin_lvl)
  );

  // Edge detection on the filtered level.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_lvl;
    end
  end

  assign rise      = pin_lvl & ~pin_prev_q;
  assign fall      = ~pin_lvl & pin_prev_q;
  assign trig_edge = (ctl.start_control == `ECT_START_RISE) ? rise : fall;
  assign opp_edge  = (ctl.start_control == `ECT_START_RISE) ? fall : rise;
  assign win_lvl   = (ctl.start_control == `ECT_START_RISE) ? pin_lvl
                                                             : ~pin_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Free-running prescaler; it never resets with the timer so that the
  // tick phase does not depend on when software starts the counter.
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Low-frequency clock is synchronised, then divided by eight.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
      fsdiv_q <= '0;
    end else begin
      fs_s1_q <= low_freq_clock;
      fs_s2_q <= fs_s1_q;
      fs_s3_q <= fs_s2_q;
      if (fs_s2_q && !fs_s3_q) begin
        fsdiv_q <= fsdiv_q + 1'b1;
      end
    end
  end

  assign fs_tick  = fs_s2_q && !fs_s3_q && (&fsdiv_q);
  assign slow_src = low_speed_mode || ctl.divider_tap_sel;

  // Source tick select; only the slowest tap works at low speed.
  always_comb begin
    case (ctl.source_clock_sel)
      `ECT_CLK_SLOW: tick = slow_src ? fs_tick : (&div_q); // R05
      `ECT_CLK_MID:  tick = !low_speed_mode
                            && (&div_q[`ECT_DIV_MID-1:0]); // R05
      `ECT_CLK_FAST: tick = !low_speed_mode
                            && (&div_q[`ECT_DIV_FAST-1:0]); // R05
      default:       tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode from mode field, start code and clock select.
  always_comb begin
    m_timer = 1'b0;
    m_ext   = 1'b0;
    m_event = 1'b0;
    m_win   = 1'b0;
    m_pw    = 1'b0;
    case (ctl.operating_mode_sel)
      `ECT_MODE_TEV: begin // R20
        m_timer = (ctl.start_control == `ECT_START_CMD);
        m_event = ctl.start_control[1]
                  && (ctl.source_clock_sel == `ECT_CLK_EXT);
        m_ext   = ctl.start_control[1]
                  && (ctl.source_clock_sel != `ECT_CLK_EXT);
      end
      `ECT_MODE_WIN: m_win = ctl.start_control[1]; // R20
      `ECT_MODE_PW:  m_pw  = ctl.start_control[1]; // R20
      default: begin
      end
    endcase
  end

  assign run     = (state_q == ECT_ST_RUN);
  assign hit     = (cnt_q == compare_limit_reg);
  assign cnt_adv = run && ((m_timer && tick) || (m_event && trig_edge)
                           || (m_win && tick && win_lvl));
  assign cap_pw  = run && m_pw
                   && (opp_edge || (!ctl.capture_edge_mode && trig_edge));

  ////////////////////////////////////////////////////////////////////////
  // Counter sequencing. Stop code or generator mode holds it cleared.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ECT_ST_STOP;
      cnt_q   <= `ECT_CNT_RESET;
      irq_q   <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      if (!(m_timer || m_ext || m_event || m_win || m_pw)) begin
        state_q <= ECT_ST_STOP; // R21
        cnt_q   <= `ECT_CNT_RESET; // R21
      end else begin
        case (state_q)
          ECT_ST_STOP: begin
            cnt_q   <= `ECT_CNT_RESET;
            state_q <= (m_ext || m_pw) ? ECT_ST_WAIT : ECT_ST_RUN;
          end
          ECT_ST_WAIT: begin
            if (trig_edge) begin
              state_q <= ECT_ST_RUN; // R06
            end
          end
          default: begin
            if (m_timer || m_win) begin
              if (tick && (m_timer || win_lvl)) begin // R13
                if (hit) begin
                  cnt_q <= `ECT_CNT_RESET; // R01
                  irq_q <= 1'b1; // R01
                end else begin
                  cnt_q <= cnt_q + 1'b1;
                end
              end
            end else if (m_event) begin
              if (trig_edge) begin
                cnt_q <= cnt_q + 1'b1; // R11
              end else if (opp_edge && hit) begin
                cnt_q <= `ECT_CNT_RESET; // R11
                irq_q <= 1'b1;
              end
            end else if (m_ext) begin
              // Extra trigger edges fall through untouched.
              if (ctl.trigger_stop_sel && opp_edge) begin
                cnt_q   <= `ECT_CNT_RESET; // R08
                state_q <= ECT_ST_WAIT;
              end else if (tick) begin
                if (hit) begin
                  cnt_q   <= `ECT_CNT_RESET; // R07
                  irq_q   <= 1'b1;
                  state_q <= ECT_ST_WAIT;
                end else begin
                  cnt_q <= cnt_q + 1'b1; // R09
                end
              end
            end else begin
              if (opp_edge) begin
                irq_q <= 1'b1; // R17
                if (ctl.capture_edge_mode) begin
                  // Next measurement starts at one, as the hardware
                  // it mimics leaves the counter resting there.
                  cnt_q   <= `ECT_CNT_REST; // R15
                  state_q <= ECT_ST_WAIT;
                end else if (tick) begin
                  cnt_q <= cnt_q + 1'b1;
                end
              end else if (trig_edge) begin
                irq_q <= 1'b1; // R17
                cnt_q <= `ECT_CNT_RESET; // R17
              end else if (tick) begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture register: pulse edges, or each timer, event or window count step when enabled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap_q <= '0;
    end else if (cap_pw) begin
      cap_q <= cnt_q; // R15
    end else if (ctl.auto_capture_en && cnt_adv) begin
      cap_q <= cnt_q; // R02
    end
  end

  assign capture_reg     = cap_q;
  assign count_value     = cnt_q;
  assign counting        = state_q[1]; // Only the run state sets this bit.
  assign timer_match_irq = irq_q; // R22

  ////////////////////////////////////////////////////////////////////////
  // Checks on the counter and its events.
  timer_wrap_a: assert property (@(posedge mclk) disable iff (rst) // R01
    (run && m_timer && tick && hit)
    |=> (cnt_q == `ECT_CNT_RESET) && irq_q && (state_q == ECT_ST_RUN))
    else $error("Timer match did not wrap with interrupt.");

  auto_cap_a: assert property (@(posedge mclk) disable iff (rst) // R02
    (ctl.auto_capture_en && cnt_adv && !m_pw)
    |=> (cap_q == $past(cnt_q)))
    else $error("Auto-capture missed a count step.");

  slow_tap_a: assert property (@(posedge mclk) disable iff (rst) // R05
    (low_speed_mode && (ctl.source_clock_sel != `ECT_CLK_SLOW))
    |-> !tick)
    else $error("Fast tap ticked in low-speed mode.");

  ext_start_a: assert property (@(posedge mclk) disable iff (rst) // R06
    (m_ext && (state_q == ECT_ST_WAIT)) |=>
    ($stable(cnt_q) && ((state_q == ECT_ST_RUN) == $past(trig_edge))))
    else $error("Trigger wait misbehaved.");

  ext_match_a: assert property (@(posedge mclk) disable iff (rst) // R07
    (m_ext && run && tick && hit
     && !(ctl.trigger_stop_sel && opp_edge))
    |=> irq_q && (cnt_q == `ECT_CNT_RESET) && (state_q == ECT_ST_WAIT))
    else $error("Trigger match did not halt.");

  ext_abort_a: assert property (@(posedge mclk) disable iff (rst) // R08
    (m_ext && run && ctl.trigger_stop_sel && opp_edge)
    |=> !irq_q && (cnt_q == `ECT_CNT_RESET) && (state_q == ECT_ST_WAIT))
    else $error("Opposite edge did not abort quietly.");

  ext_ignore_a: assert property (@(posedge mclk) disable iff (rst) // R09
    (m_ext && run && !ctl.trigger_stop_sel && (rise || fall) && !tick)
    |=> $stable(cnt_q) && (state_q == ECT_ST_RUN) && !irq_q)
    else $error("Edge disturbed trigger-start counting.");

  event_cnt_a: assert property (@(posedge mclk) disable iff (rst) // R11
    (m_event && run && trig_edge) |=> (cnt_q == $past(cnt_q) + 1'b1)
    ##1 !irq_q)
    else $error("Event edge did not count.");

  window_gate_a: assert property (@(posedge mclk) disable iff (rst) // R13
    (m_win && run && !(tick && win_lvl)) |=> $stable(cnt_q))
    else $error("Window counted outside its gate.");

  pw_single_a: assert property (@(posedge mclk) disable iff (rst) // R15
    (m_pw && run && ctl.capture_edge_mode && opp_edge)
    |=> irq_q && (cnt_q == `ECT_CNT_REST) && (cap_q == $past(cnt_q))
        && (state_q == ECT_ST_WAIT))
    else $error("Single-edge capture wrong.");

  pw_double_a: assert property (@(posedge mclk) disable iff (rst) // R17
    (m_pw && run && !ctl.capture_edge_mode && trig_edge)
    |=> irq_q && (cnt_q == `ECT_CNT_RESET) && (cap_q == $past(cnt_q))
        && (state_q == ECT_ST_RUN))
    else $error("Double-edge cycle capture wrong.");

  ppg_idle_a: assert property (@(posedge mclk) disable iff (rst) // R20
    (ctl.operating_mode_sel == `ECT_MODE_PPG)
    |=> (state_q == ECT_ST_STOP) && !irq_q)
    else $error("Generator mode did not idle.");

  stop_clear_a: assert property (@(posedge mclk) disable iff (rst) // R21
    (ctl.start_control == `ECT_START_STOP)
    |=> (cnt_q == `ECT_CNT_RESET) && !run)
    else $error("Stop code did not clear counter.");

  irq_pulse_a: assert property (@(posedge mclk) disable iff (rst) // R22
    irq_q |=> !irq_q)
    else $error("Interrupt held longer than one cycle.");

endmodule

`default_nettype wire

/* File: sim/ect_pulse_src.sv */
// Model of the pulse source that drives the timer's count input pin.
`timescale 1ns/1ps
`default_nettype none

module ect_pulse_src (
  input  wire logic mclk,  // System clock.
  output logic      pin    // Count input pin, always driven.
);
  ////////////////////////////////////////////////////////////////////////
  // The pin rests low; the source never floats it.
  initial pin = 1'b0;

  // Hold one level for a span of cycles, changing just after a falling
  // edge. Spans stay long against the filter and the source taps, except
  // where the bench asks for a glitch on purpose.
  task automatic drive(input logic lvl, input int cyc);
    @(negedge mclk);
    pin = lvl;
    repeat (cyc - 1) @(negedge mclk);
  endtask
endmodule

`default_nettype wire

/* File: sim/tb_event_capture_timer.sv */
// Self-checking bench for the event capture timer.
`timescale 1ns/1ps
`default_nettype none

`include "ect_defs.svh"

module tb_event_capture_timer
  import ect_pkg::*;
;
  localparam int LIMIT = 60000; // Cycle ceiling for the whole run.
  logic        mclk;
  logic        rst;
  ect_ctrl_t   ctrl;
  logic [15:0] lim;
  logic        lsm;
  logic        lfc;
  wire logic   pin;
  logic [15:0] cap;
  logic [15:0] cnt;
  logic        run;
  logic        irq;
  int          err_total;
  int          n_checks;
  int          irq_cnt;
  int          cyc_total;
  int          seed;
  int          n;
  int          w;
  int          w2;
  int          i0;
  logic [15:0] c0;
  logic        ev_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Design and the pulse source on its pin.
  ect_timer DUT (.mclk(mclk), .rst(rst), .timer_control_reg(ctrl),
    .compare_limit_reg(lim), .low_speed_mode(lsm), .ext_count_input(pin),
    .low_freq_clock(lfc), .capture_reg(cap), .count_value(cnt),
    .counting(run), .timer_match_irq(irq));
  ect_pulse_src src (.mclk(mclk), .pin(pin));

  // Clocks: the low-frequency clock is 64 system periods long.
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always begin
    repeat (32) @(negedge mclk);
    lfc = ~lfc;
  end

  // Count requests at the edge after they show, so no race with readers.
  always @(posedge mclk) begin
    cyc_total = cyc_total + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc_total == LIMIT) begin
      err_total = err_total + 1;
      $display("mismatch timeout expected 0 seen %0d", cyc_total);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Fields change only while stopped; the start code follows a cycle later.
  task automatic cfg(input logic [1:0] m, s, ck, input logic ac, cm, ts,
                     dt);
    @(negedge mclk);
    ctrl = '{m, `ECT_START_STOP, ck, ac, cm, ts, dt};
    @(negedge mclk);
    ctrl.start_control = s;
  endtask

  // Cycles until the next request pulse, bounded by lmt.
  task automatic wait_irq(input int lmt, output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (irq !== 1'b1 && k < lmt);
  endtask

  // System cycles per count tick for a clock select setting.
  function automatic int tick_len(input logic [1:0] ck, input logic dt, ls);
    if (ck == `ECT_CLK_SLOW)
      return (dt || ls) ? 64 * (1 << `ECT_FS_DIV) : 1 << `ECT_DIV_SLOW;
    return (ck == `ECT_CLK_MID) ? 1 << `ECT_DIV_MID : 1 << `ECT_DIV_FAST;
  endfunction

  // Pulse edges pass the filter with the same delay, so a measured width
  // is only known to within a tick of the divider phase.
  function automatic logic [15:0] in_rng(input int v, lo, hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'ha664dde4;
    rst = 1'b1;
    ctrl = '0;
    lim = 16'h0000;
    lsm = 1'b0;
    lfc = 1'b0;
    err_total = 0;
    n_checks = 0;
    irq_cnt = 0;
    cyc_total = 0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("rst_count", cnt, `ECT_CNT_RESET);
    chk("rst_flags", {cap[13:0], run, irq}, 16'h0000);

    // Timer mode over every source tap, the low-frequency ones included.
    for (int k = 0; k < 5; k++) begin
      lim = 16'h0002 + 16'($random(seed) & 3);
      lsm = (k == 4);
      cfg(`ECT_MODE_TEV, `ECT_START_CMD, (k < 3) ? 2'(k) : `ECT_CLK_SLOW,
          1'b1, 1'b0, 1'b0, k == 3);
      wait_irq(14000, n);
      wait_irq(14000, n);
      chk("timer_period", 16'(n), 16'((lim + 1) *
          tick_len(ctrl.source_clock_sel, k == 3, lsm)));
      chk("timer_wrap", cnt, 16'h0000);
      chk("auto_capture", cap, lim);
      chk("irq_seen", 16'(irq), 16'h0001);
      @(negedge mclk);
      chk("irq_pulse", 16'(irq), 16'h0000);
    end
    lsm = 1'b0;
    ctrl.start_control = `ECT_START_STOP;
    repeat (2) @(negedge mclk);
    chk("stop_clear", {cnt[14:0], run}, 16'h0000);
    i0 = irq_cnt;
    cfg(`ECT_MODE_PPG, `ECT_START_CMD, `ECT_CLK_FAST, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (100) @(negedge mclk);
    chk("gen_idle", {cnt[14:0], run}, 16'h0000);
    chk("gen_no_irq", 16'(irq_cnt - i0), 16'h0000);
    $display("test timer done");

    // Event counting on a random edge, then a glitch with and without filter.
    lim = 16'h0002 + 16'($random(seed) & 3);
    ev_lvl = 1'($random(seed) & 1);
    cfg(`ECT_MODE_TEV, ev_lvl ? `ECT_START_RISE : `ECT_START_FALL,
        `ECT_CLK_EXT, 1'b1, 1'b0, 1'b0, 1'b0);
    src.drive(!ev_lvl, 20);
    i0 = irq_cnt;
    for (int k = 1; k <= lim; k++) begin
      src.drive(ev_lvl, 20);
      chk("evt_count", cnt, 16'(k));
      chk("evt_capture", cap, 16'(k - 1));
      src.drive(!ev_lvl, 20);
    end
    chk("evt_irq", 16'(irq_cnt - i0), 16'h0001);
    chk("evt_clear", cnt, 16'h0000);
    src.drive(ev_lvl, 4);
    src.drive(!ev_lvl, 20);
    chk("glitch_reject", cnt, 16'h0000);
    lsm = 1'b1;
    src.drive(ev_lvl, 3);
    src.drive(!ev_lvl, 20);
    chk("bypass_count", cnt, 16'h0001);
    lsm = 1'b0;
    $display("test event done");

    // Window mode with both polarities.
    lim = 16'h0100;
    for (int k = 0; k < 2; k++) begin
      cfg(`ECT_MODE_WIN, k ? `ECT_START_FALL : `ECT_START_RISE,
          `ECT_CLK_FAST, 1'b0, 1'b0, 1'b0, 1'b0);
      src.drive(1'(k), 40);
      c0 = cnt;
      src.drive(1'(k), 80);
      chk("win_closed", cnt, c0);
      src.drive(1'(!k), 160);
      chk("win_open", in_rng(int'(cnt) - int'(c0), 17, 20),
          16'h0001);
    end
    $display("test window done");

    // Trigger start, with and without stop on the opposite edge.
    lim = 16'h0014;
    for (int k = 0; k < 2; k++) begin
      cfg(`ECT_MODE_TEV, `ECT_START_RISE, `ECT_CLK_FAST, 1'b0, 1'b0, 1'(k),
          1'b0);
      src.drive(1'b0, 40);
      chk("trg_wait", 16'(run), 16'h0000);
      i0 = irq_cnt;
      src.drive(1'b1, 60);
      chk("trg_run", 16'(run), 16'h0001);
      src.drive(1'b0, 40);
      chk("trg_opposite", 16'(run), 16'(k == 0));
      if (k) begin
        chk("trg_halt", cnt, 16'h0000);
        chk("trg_silent", 16'(irq_cnt - i0), 16'h0000);
        src.drive(1'b1, 30);
        chk("trg_restart", 16'(run), 16'h0001);
      end else begin
        src.drive(1'b1, 20);
        wait_irq(400, n);
        chk("trg_match", in_rng(n, 1, 100), 16'h0001);
        repeat (2) @(negedge mclk);
        chk("trg_match_halt", {cnt[14:0], run}, 16'h0000);
      end
    end
    $display("test trigger done");

    // Single-edge capture; the first capture is thrown away.
    lim = 16'hffff;
    cfg(`ECT_MODE_PW, `ECT_START_RISE, `ECT_CLK_FAST, 1'b0, 1'b1, 1'b0, 1'b0);
    w = 80 + ($random(seed) & 63);
    for (int k = 0; k < 2; k++) begin
      i0 = irq_cnt;
      src.drive(1'b0, 30);
      src.drive(1'b1, w);
      src.drive(1'b0, 40);
    end
    chk("pw_single", in_rng(int'(cap), w / 8 - 1, w / 8 + 2),
        16'h0001);
    chk("pw_rest", cnt, `ECT_CNT_REST);
    chk("pw_rest_halt", 16'(run), 16'h0000);
    chk("pw_irq", 16'(irq_cnt - i0), 16'h0001);
    $display("test single done");

    // Double-edge capture of a cycle that begins low.
    cfg(`ECT_MODE_PW, `ECT_START_FALL, `ECT_CLK_FAST, 1'b0, 1'b0, 1'b0, 1'b0);
    w2 = 60 + ($random(seed) & 31);
    src.drive(1'b1, 30);
    i0 = irq_cnt;
    src.drive(1'b0, w);
    src.drive(1'b1, w2);
    chk("pw_first", in_rng(int'(cap), w / 8 - 1, w / 8 + 1), 16'h0001);
    chk("pw_keeps", 16'(run), 16'h0001);
    src.drive(1'b0, 20);
    chk("pw_cycle", in_rng(int'(cap), (w + w2) / 8 - 1, (w + w2) / 8 + 1),
        16'h0001);
    chk("pw_two_irq", 16'(irq_cnt - i0), 16'h0002);
    chk("pw_cleared", in_rng(int'(cnt), 0, 3), 16'h0001);
    $display("test double done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
